// *** mac_slice_pkg.sv ***
// shared widths, encodings and carriers for the multiply-accumulate slice
`default_nettype none
package mac_slice_pkg;
    // operand and result widths
    localparam int A_WIDTH = 25;
    localparam int B_WIDTH = 18;
    localparam int P_WIDTH = 48;
    localparam int PROD_WIDTH = A_WIDTH + B_WIDTH;
    // upper part of the bypass operand, a sign-extended to fill 48 bits
    localparam int AB_HI_WIDTH = P_WIDTH - B_WIDTH;
    localparam int AB_EXT_WIDTH = AB_HI_WIDTH - A_WIDTH;
    // simd lane layout: four 12-bit segments make up the 48-bit adder
    localparam int LANE_WIDTH = 12;
    localparam int LANE_COUNT = 4;
    // lane index where the upper half starts in dual 24-bit mode
    localparam int HALF_LANE = 2;
    // timing target of the fully pipelined datapath, in MHz
    localparam int TARGET_FMAX_MHZ = 550;
    // reset values and constants met by the logic
    localparam logic [P_WIDTH-1:0] RESULT_RESET = 48'h0;
    localparam logic [P_WIDTH-1:0] COUNT_STEP = 48'h1;
    localparam logic [LANE_COUNT-1:0] CARRY_RESET = 4'h0;

    // source of the z operand of the adder
    typedef enum logic [1:0] {Z_ZERO, Z_C, Z_P, Z_CASCADE} z_src_type;
    // operation of the final stage
    typedef enum logic [2:0] {
        ALU_ADD, ALU_SUB, ALU_LOGIC, ALU_CNT_UP, ALU_CNT_DOWN
    } alu_op_type;
    // adder split
    typedef enum logic [1:0] {
        SIMD_ONE48, SIMD_TWO24, SIMD_FOUR12
    } simd_type;
    // the ten bitwise functions of x and z
    typedef enum logic [3:0] {
        FN_AND, FN_OR, FN_XOR, FN_XNOR, FN_NAND, FN_NOR,
        FN_X_ANDN_Z, FN_X_ORN_Z, FN_NX_AND_Z, FN_NX_OR_Z
    } logic_fn_type;

    // operands from the fabric
    typedef struct packed {
        logic [A_WIDTH-1:0] a;
        logic [B_WIDTH-1:0] b;
        logic [P_WIDTH-1:0] c;
        logic [A_WIDTH-1:0] d;
    } operand_type;
    // run-time operation selects
    typedef struct packed {
        logic use_pre;
        logic pre_sub;
        logic bypass_mul;
        z_src_type z_sel;
        alu_op_type alu_op;
        logic_fn_type logic_fn;
        simd_type simd;
    } ctrl_type;
    // per-stage pipeline register selects
    typedef struct packed {
        logic in_reg;
        logic pre_reg;
        logic mul_reg;
    } pipe_sel_type;
    // pattern detector compare value and don't-care mask
    typedef struct packed {
        logic [P_WIDTH-1:0] pattern;
        logic [P_WIDTH-1:0] mask;
    } pattern_type;
endpackage
`default_nettype wire

// *** mac_slice.sv ***
// multiply-accumulate slice: pre-adder, multiplier, simd alu, pattern detect
`default_nettype none

// Behaviour
// - signed 25 by 18 full product
// - 48-bit accumulator adds results into itself
// - run-time bypass feeds two 48-bit operands
// - simd split into 2x24 or 4x12 lanes
// - logic unit with ten selectable functions
// - optional pre-adder before the multiplier
// - 48-bit pattern detector flags match, rounding
// - pattern detector with logic spans 96 bits
// - accumulator counts up or down
// - selectable pipeline registers, cascade bus out
// - pipelined datapath targets 550 MHz
module mac_slice
    import mac_slice_pkg::*;
(
    input wire logic mclk, // single clock
    input wire logic sys_rst, // synchronous reset, active high
    input wire logic clk_en, // freezes all state while low; sys_rst still clears it
    input wire operand_type operands, // a, b, c, d from the fabric
    input wire ctrl_type ctrl, // operation selects, used at the pre-adder, the x and z selects and the alu
    input wire pipe_sel_type pipe_sel, // stage register selects
    input wire pattern_type pat, // pattern and mask
    input wire logic [P_WIDTH-1:0] cascade_in, // from the slice below
    input wire logic match_cascade_in, // match of the slice below
    output logic [P_WIDTH-1:0] result, // registered alu result
    output logic [LANE_COUNT-1:0] carry_out, // per 12-bit segment
    output logic pattern_match, // result matches pattern
    output logic pattern_match_inv, // result matches inverted pattern
    output logic pattern_match_prev, // match of the previous result
    output logic wide_match, // match joined with the slice below
    output logic [P_WIDTH-1:0] cascade_out // copy of result, slice above
);

    // true where segment idx opens a new lane in the chosen split
    function automatic logic lane_starts(input simd_type mode,
                                         input int idx);
        logic starts;
        starts = 1'b0;
        unique case (mode)
            SIMD_ONE48: starts = 1'b0;
            SIMD_TWO24: starts = (idx == HALF_LANE);
            SIMD_FOUR12: starts = 1'b1;
            default: starts = 1'b0;
        endcase
        return starts;
    endfunction

    // bitwise function of x and z
    function automatic logic [P_WIDTH-1:0] logic_eval(
        input logic_fn_type fn,
        input logic [P_WIDTH-1:0] x,
        input logic [P_WIDTH-1:0] z);
        logic [P_WIDTH-1:0] r;
        r = '0;
        unique case (fn)
            FN_AND: r = x & z;
            FN_OR: r = x | z;
            FN_XOR: r = x ^ z;
            FN_XNOR: r = ~(x ^ z);
            FN_NAND: r = ~(x & z);
            FN_NOR: r = ~(x | z);
            FN_X_ANDN_Z: r = x & ~z;
            FN_X_ORN_Z: r = x | ~z;
            FN_NX_AND_Z: r = ~x & z;
            FN_NX_OR_Z: r = ~x | z;
            default: r = '0; // six codes are unused
        endcase
        return r;
    endfunction

    // input stage registers
    logic [A_WIDTH-1:0] a_reg; // a after input register
    logic [B_WIDTH-1:0] b_reg; // b after input register
    logic [P_WIDTH-1:0] c_reg; // c after input register
    logic [A_WIDTH-1:0] d_reg; // d after input register
    // selected outputs of the input stage
    logic [A_WIDTH-1:0] a_s;
    logic [B_WIDTH-1:0] b_s;
    logic [P_WIDTH-1:0] c_s;
    logic [A_WIDTH-1:0] d_s;
    // pre-adder stage
    logic [A_WIDTH-1:0] pre_next; // pre-adder result
    logic [A_WIDTH-1:0] pre_reg; // pre-adder register
    logic [B_WIDTH-1:0] b2_reg; // b delayed to stay aligned with pre_reg
    logic [A_WIDTH-1:0] pre_s;
    logic [B_WIDTH-1:0] b2_s;
    // multiplier stage
    logic signed [PROD_WIDTH-1:0] prod_next; // full signed product
    logic signed [PROD_WIDTH-1:0] prod_reg; // multiplier register
    logic signed [PROD_WIDTH-1:0] prod_s;
    // alu operands and results
    logic [P_WIDTH-1:0] x_op; // product, bypass pair or count step
    logic [P_WIDTH-1:0] z_op; // c, result, cascade or zero
    logic [P_WIDTH-1:0] x_eff; // x inverted for subtraction
    logic sub_en; // subtract or count down
    logic [LANE_WIDTH:0] lane_sum [LANE_COUNT]; // segment sum with carry
    logic [LANE_COUNT-1:0] lane_cin; // carry into each segment
    logic [LANE_COUNT-1:0] lane_cout; // carry out of each segment
    logic [P_WIDTH-1:0] sum_all; // joined segment sums
    logic [P_WIDTH-1:0] alu_next; // value loaded into result
    logic match_next; // pattern compare of alu_next
    logic match_inv_next; // compare against the inverted pattern

    // input registers; bypassed by pipe_sel.in_reg low
    // input register stage
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            a_reg <= '0;
            b_reg <= '0;
            c_reg <= '0;
            d_reg <= '0;
        end else if (clk_en) begin
            a_reg <= operands.a;
            b_reg <= operands.b;
            c_reg <= operands.c;
            d_reg <= operands.d;
        end
    end

    // select registered or direct operands
    always_comb begin
        a_s = pipe_sel.in_reg ? a_reg : operands.a;
        b_s = pipe_sel.in_reg ? b_reg : operands.b;
        c_s = pipe_sel.in_reg ? c_reg : operands.c;
        d_s = pipe_sel.in_reg ? d_reg : operands.d;
    end

    // pre-adder: d plus or minus a, wraps at 25 bits like the hardware
    // pre-adder ahead of multiply
    always_comb begin
        if (!ctrl.use_pre) begin
            pre_next = a_s;
        end else if (ctrl.pre_sub) begin
            pre_next = d_s - a_s;
        end else begin
            pre_next = d_s + a_s;
        end
    end

    // pre-adder register; b rides along so both factors stay aligned
    // pre-adder register stage
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pre_reg <= '0;
            b2_reg <= '0;
        end else if (clk_en) begin
            pre_reg <= pre_next;
            b2_reg <= b_s;
        end
    end

    // select registered or direct pre-adder output
    always_comb begin
        pre_s = pipe_sel.pre_reg ? pre_reg : pre_next;
        b2_s = pipe_sel.pre_reg ? b2_reg : b_s;
    end

    // two's complement multiply, all 43 product bits kept
    // full signed product
    always_comb begin
        prod_next = signed'(pre_s) * signed'(b2_s);
    end

    // product register; with every stage on, each path spans one
    // operation, which is what lets a fast process close timing
    // pipelined multiply stage
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            prod_reg <= '0;
        end else if (clk_en) begin
            prod_reg <= prod_next;
        end
    end

    // select registered or direct product
    always_comb begin
        prod_s = pipe_sel.mul_reg ? prod_reg : prod_next;
    end

    // x operand: count step, bypass pair or extended product
    always_comb begin
        if (ctrl.alu_op == ALU_CNT_UP || ctrl.alu_op == ALU_CNT_DOWN) begin
            x_op = COUNT_STEP;
        end else if (ctrl.bypass_mul) begin
            x_op = {{AB_EXT_WIDTH{a_s[A_WIDTH-1]}}, a_s, b_s};
        end else begin
            x_op = P_WIDTH'(prod_s);
        end
    end

    // z operand; counting always works on the stored result
    always_comb begin
        if (ctrl.alu_op == ALU_CNT_UP || ctrl.alu_op == ALU_CNT_DOWN) begin
            z_op = result;
        end else begin
            unique case (ctrl.z_sel)
                Z_ZERO: z_op = '0;
                Z_C: z_op = c_s;
                Z_P: z_op = result;
                Z_CASCADE: z_op = cascade_in;
            endcase
        end
    end

    // subtract as z plus inverted x plus one in each lane
    always_comb begin
        sub_en = (ctrl.alu_op == ALU_SUB) || (ctrl.alu_op == ALU_CNT_DOWN);
        x_eff = sub_en ? ~x_op : x_op;
    end

    // segmented adder; a lane boundary cuts the carry and reseeds it
    genvar gi;
    for (gi = 0; gi < LANE_COUNT; gi++) begin : g_lane
        if (gi == 0) begin : g_first
            assign lane_cin[gi] = sub_en;
        end else begin : g_next
            assign lane_cin[gi] = lane_starts(ctrl.simd, gi) ?
                                  sub_en : lane_cout[gi-1];
        end
        assign lane_sum[gi] = {1'b0, z_op[gi*LANE_WIDTH +: LANE_WIDTH]}
                            + {1'b0, x_eff[gi*LANE_WIDTH +: LANE_WIDTH]}
                            + {{LANE_WIDTH{1'b0}}, lane_cin[gi]};
        assign lane_cout[gi] = lane_sum[gi][LANE_WIDTH];
        assign sum_all[gi*LANE_WIDTH +: LANE_WIDTH] =
            lane_sum[gi][LANE_WIDTH-1:0];
    end

    // final stage select; the sum drops its top carry, so the result
    // wraps modulo 2**48 and never saturates
    always_comb begin
        unique case (ctrl.alu_op)
            ALU_LOGIC: alu_next = logic_eval(ctrl.logic_fn, x_op, z_op);
            ALU_ADD, ALU_SUB, ALU_CNT_UP, ALU_CNT_DOWN: alu_next = sum_all;
            default: alu_next = result; // unused codes hold the value
        endcase
    end

    // masked compare; a set mask bit is a don't-care
    // 48-bit pattern compare
    always_comb begin
        match_next = (((alu_next ^ pat.pattern) & ~pat.mask) == '0);
        match_inv_next = (((alu_next ^ ~pat.pattern) & ~pat.mask) == '0);
    end

    // result register: accumulator, counter and cascade source at once
    // accumulator update
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            result <= RESULT_RESET;
            cascade_out <= RESULT_RESET;
        end else if (clk_en) begin
            result <= alu_next;
            cascade_out <= alu_next;
        end
    end

    // per-segment carries; only those at a lane's top end mean much
    // independent lane carries
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            carry_out <= CARRY_RESET;
        end else if (clk_en) begin
            carry_out <= (ctrl.alu_op == ALU_LOGIC) ? CARRY_RESET : lane_cout;
        end
    end

    // pattern flags; the previous flag lets the fabric do convergent
    // rounding without its own register
    // match flags for rounding
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pattern_match <= 1'b0;
            pattern_match_inv <= 1'b0;
            pattern_match_prev <= 1'b0;
        end else if (clk_en) begin
            pattern_match <= match_next;
            pattern_match_inv <= match_inv_next;
            pattern_match_prev <= pattern_match;
        end
    end

    // joined match: two slices in logic mode compare 96 bits; the
    // neighbour's flag must be aligned with this slice's alu output
    // 96-bit wide logic match
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wide_match <= 1'b0;
        end else if (clk_en) begin
            wide_match <= match_next & match_cascade_in;
        end
    end

endmodule
`default_nettype wire

// *** fabric_model.sv ***
// fabric-side model that feeds operands and selects into the slice
`default_nettype none
module fabric_model
    import mac_slice_pkg::*;
(
    input wire logic mclk,
    output logic clk_en,
    output operand_type operands,
    output ctrl_type ctrl,
    output pipe_sel_type pipe_sel,
    output pattern_type pat,
    output logic [P_WIDTH-1:0] cascade_in,
    output logic match_cascade_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // quiet fabric at time zero, slice stalled until the first operation
    initial begin
        clk_en = 1'b0;
        operands = '0;
        ctrl = '0;
        pipe_sel = '0;
        pat = '0;
        cascade_in = 48'h0;
        match_cascade_in = 1'b0;
    end
    // one operation after a falling edge; a slow producer stalls first
    task automatic put(input operand_type o, input ctrl_type c,
        input int stall);
        repeat (stall) begin
            @(negedge mclk);
            clk_en = 1'b0;
        end
        @(negedge mclk);
        clk_en = 1'b1;
        operands = o;
        ctrl = c;
    endtask
endmodule
`default_nettype wire

// *** mac_slice_monitor.sv ***
// port-level assertions for the multiply-accumulate slice
`default_nettype none
module mac_slice_monitor
    import mac_slice_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire operand_type operands,
    input wire ctrl_type ctrl,
    input wire pipe_sel_type pipe_sel,
    input wire pattern_type pat,
    input wire logic [P_WIDTH-1:0] cascade_in,
    input wire logic match_cascade_in,
    input wire logic [P_WIDTH-1:0] result,
    input wire logic [LANE_COUNT-1:0] carry_out,
    input wire logic pattern_match,
    input wire logic pattern_match_inv,
    input wire logic pattern_match_prev,
    input wire logic wide_match,
    input wire logic [P_WIDTH-1:0] cascade_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // product widened in a signed context so the sign carries up
    logic signed [P_WIDTH-1:0] prod_ext;
    logic [P_WIDTH-1:0] x_byp;
    logic [LANE_COUNT-1:0] lane_cy;
    logic [12:0] lane_sum;
    assign prod_ext = $signed(operands.a) * $signed(operands.b);
    assign x_byp = {{5{operands.a[24]}}, operands.a, operands.b};
    // carry of each 12-bit lane on its own, nothing from below
    always_comb begin
        lane_sum = 13'h0;
        for (int i = 0; i < LANE_COUNT; i++) begin
            lane_sum = {1'b0, x_byp[12*i +: 12]}
                + {1'b0, operands.c[12*i +: 12]};
            lane_cy[i] = lane_sum[12];
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // one enabled edge with the stage registers bypassed
    sequence s_plain;
        clk_en && pipe_sel == 3'h0 && ctrl.simd == SIMD_ONE48;
    endsequence
    // the previous edge loaded fresh values
    sequence s_fresh;
        $past(clk_en) && !$past(sys_rst);
    endsequence
    a_mac_accum: assert property (s_plain ##0 (ctrl.alu_op == ALU_ADD
        && ctrl.z_sel == Z_P && !ctrl.bypass_mul && !ctrl.use_pre) |=>
        result == $past(result) + $past(prod_ext))
        else $error("accumulate result wrong");
    a_bypass_add: assert property (s_plain ##0 (ctrl.alu_op == ALU_ADD
        && ctrl.z_sel == Z_C && ctrl.bypass_mul) |=>
        result == $past(operands.c) + $past(x_byp))
        else $error("bypass sum wrong");
    a_count_up: assert property (s_plain ##0 ctrl.alu_op == ALU_CNT_UP
        |=> result == $past(result) + 48'h1)
        else $error("count step wrong");
    a_frozen_hold: assert property (!clk_en |=> $stable(result)
        && $stable(carry_out) && $stable(pattern_match))
        else $error("state moved while stalled");
    a_logic_nocarry: assert property (clk_en
        && ctrl.alu_op == ALU_LOGIC |=> carry_out == 4'h0)
        else $error("carry set in logic op");
    a_lane_carry: assert property (clk_en && pipe_sel == 3'h0
        && ctrl.simd == SIMD_FOUR12 && ctrl.alu_op == ALU_ADD
        && ctrl.z_sel == Z_C && ctrl.bypass_mul |=>
        carry_out == $past(lane_cy))
        else $error("lane carry wrong");
    a_match_prev: assert property (clk_en
        |=> pattern_match_prev == $past(pattern_match))
        else $error("previous match wrong");
    a_match_value: assert property (s_fresh |-> pattern_match ==
        (((result ^ $past(pat.pattern)) & ~$past(pat.mask)) == 48'h0))
        else $error("pattern match wrong");
    a_wide_match: assert property (s_fresh |-> wide_match ==
        (pattern_match && $past(match_cascade_in)))
        else $error("joined match wrong");
    a_cascade_copy: assert property (cascade_out == result)
        else $error("cascade copy differs");
endmodule
bind mac_slice mac_slice_monitor mac_slice_monitor_i (.mclk, .sys_rst,
    .clk_en, .operands, .ctrl, .pipe_sel, .pat, .cascade_in,
    .match_cascade_in, .result, .carry_out, .pattern_match,
    .pattern_match_inv, .pattern_match_prev, .wide_match, .cascade_out);
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the multiply-accumulate slice
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
    err_total++; $display("CHECK FAILED t=%0t got=%h exp=%h", \
    $time, (g), (e)); end end
module testbench
    import mac_slice_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en, match_cascade_in, pattern_match, pattern_match_inv;
    logic pattern_match_prev, wide_match;
    operand_type operands;
    ctrl_type ctrl, c;
    pipe_sel_type pipe_sel;
    pattern_type pat;
    logic [P_WIDTH-1:0] cascade_in, result, cascade_out, x, z, e;
    logic [LANE_COUNT-1:0] carry_out;
    int err_total = 0;
    int comparisons = 0;
    // all-ones x against a seed of one per lane: add, then subtract
    logic [47:0] res_tab [6] = '{48'h001001001000, 48'h001000001000,
        48'h0, 48'h001001001002, 48'h001002001002, 48'h002002002002};
    logic [3:0] cy_tab [6] = '{4'h8, 4'ha, 4'hf, 4'h0, 4'h0, 4'h0};
    // only lane tops carry meaning in the wider splits
    logic [3:0] msk [3] = '{4'h8, 4'ha, 4'hf};
    logic [47:0] pt [3] = '{48'h12345, 48'hfffffffedcba, 48'h12340};
    logic [47:0] pm [3] = '{48'h0, 48'h0, 48'hf};
    logic mci [3] = '{1'b1, 1'b1, 1'b0};
    logic [1:0] fl [3] = '{2'b10, 2'b01, 2'b10};
    logic pv [3] = '{1'b0, 1'b1, 1'b0};
    // 25 MHz
    always #20 mclk = ~mclk;
    fabric_model fabric_model_i (.mclk, .clk_en, .operands, .ctrl,
        .pipe_sel, .pat, .cascade_in, .match_cascade_in);
    mac_slice mac_slice_i (.mclk, .sys_rst, .clk_en, .operands, .ctrl,
        .pipe_sel, .pat, .cascade_in, .match_cascade_in, .result,
        .carry_out, .pattern_match, .pattern_match_inv,
        .pattern_match_prev, .wide_match, .cascade_out);
    function automatic ctrl_type mk(input alu_op_type op,
        input z_src_type zs, input logic byp, input simd_type s);
        ctrl_type r;
        r = '0;
        r.alu_op = op;
        r.z_sel = zs;
        r.bypass_mul = byp;
        r.simd = s;
        return r;
    endfunction
    // one operation held for n enabled edges, sampled once settled
    task automatic run(input logic [24:0] a, input logic [17:0] b,
        input logic [47:0] cc, input ctrl_type k, input int n,
        input int st);
        fabric_model_i.put('{a, b, cc, 25'h7}, k, st);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic finish_test();
        $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // a hang ends the run as a mismatch
    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        finish_test();
    end
    initial begin
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        sys_rst = 1'b0;
        `CHK(result, 48'h0)
        c = mk(ALU_ADD, Z_P, 1'b0, SIMD_ONE48);
        run(25'h1fffffd, 18'h5, 48'h0, c, 1, 0);
        `CHK(result, 48'hfffffffffff1)
        run(25'h1fffffd, 18'h5, 48'h0, c, 1, 0);
        `CHK(cascade_out, 48'hffffffffffe2)
        c.z_sel = Z_ZERO;
        run(25'h1000000, 18'h20000, 48'h0, c, 1, 0);
        `CHK(result, 48'h020000000000)
        run(25'h1000000, 18'h1ffff, 48'h0, c, 1, 0);
        `CHK(result, 48'hfe0001000000)
        $display("done multiply");
        c = mk(ALU_ADD, Z_C, 1'b1, SIMD_ONE48);
        run(25'h1000001, 18'h2aaaa, 48'h1, c, 1, 0);
        e = {5'h1f, 25'h1000001, 18'h2aaaa} + 48'h1;
        `CHK(result, e)
        @(negedge mclk);
        fabric_model_i.cascade_in = 48'h100;
        c.z_sel = Z_CASCADE;
        run(25'h0, 18'h5, 48'h0, c, 1, 0);
        `CHK(cascade_out, 48'h105)
        for (int i = 0; i < 6; i++) begin
            c = mk(alu_op_type'(i / 3), Z_C, 1'b1, simd_type'(i % 3));
            run(25'h1ffffff, 18'h3ffff, 48'h001001001001, c, 1, 0);
            `CHK(result, res_tab[i])
            `CHK(carry_out & msk[i % 3], cy_tab[i])
        end
        $display("done bypass and lanes");
        x = {5'h0, 25'h0f0f0f0, 18'h0f0f0};
        z = 48'h00ff00ff00ff;
        for (int f = 0; f < 10; f++) begin
            c = mk(ALU_LOGIC, Z_C, 1'b1, SIMD_ONE48);
            c.logic_fn = logic_fn_type'(f);
            run(25'h0f0f0f0, 18'h0f0f0, z, c, 1, 0);
            case (f)
                0: e = x & z;
                1: e = x | z;
                2: e = x ^ z;
                3: e = ~(x ^ z);
                4: e = ~(x & z);
                5: e = ~(x | z);
                6: e = x & ~z;
                7: e = x | ~z;
                8: e = ~x & z;
                default: e = ~x | z;
            endcase
            `CHK(result, e)
        end
        // an unused operation code must leave the result untouched
        c.alu_op = alu_op_type'(3'h5);
        run(25'h0f0f0f0, 18'h0f0f0, z, c, 1, 0);
        `CHK(result, e)
        // an unused logic function code yields zero
        c.alu_op = ALU_LOGIC;
        c.logic_fn = logic_fn_type'(4'ha);
        run(25'h0f0f0f0, 18'h0f0f0, z, c, 1, 0);
        `CHK(result, 48'h0)
        c = mk(ALU_ADD, Z_ZERO, 1'b0, SIMD_ONE48);
        c.use_pre = 1'b1;
        run(25'h2, 18'h3, 48'h0, c, 1, 0);
        `CHK(result, 48'h1b)
        c.pre_sub = 1'b1;
        run(25'h9, 18'h3, 48'h0, c, 1, 0);
        `CHK(result, 48'hfffffffffffa)
        $display("done logic and pre-adder");
        c = mk(ALU_ADD, Z_ZERO, 1'b1, SIMD_ONE48);
        for (int k = 0; k < 3; k++) begin
            fabric_model_i.put('{25'h0, 18'h12345, 48'h0, 25'h7}, c, 0);
            fabric_model_i.pat = '{pt[k], pm[k]};
            fabric_model_i.match_cascade_in = mci[k];
            @(posedge mclk);
            #1;
            `CHK({pattern_match, pattern_match_inv}, fl[k])
            `CHK(pattern_match_prev, pv[k])
            `CHK(wide_match, fl[k][1] & mci[k])
        end
        $display("done pattern");
        c = mk(ALU_CNT_UP, Z_ZERO, 1'b0, SIMD_ONE48);
        run(25'h0, 18'h0, 48'h0, c, 3, 0);
        `CHK(result, 48'h12348)
        run(25'h0, 18'h0, 48'h0, c, 1, 2);
        `CHK(result, 48'h12349)
        @(negedge mclk);
        sys_rst = 1'b1;
        fabric_model_i.clk_en = 1'b0;
        fabric_model_i.pipe_sel = 3'h7;
        @(negedge mclk);
        sys_rst = 1'b0;
        `CHK(result, 48'h0)
        c.alu_op = ALU_CNT_DOWN;
        run(25'h0, 18'h0, 48'h0, c, 1, 0);
        `CHK(result, 48'hffffffffffff)
        $display("done counter");
        c = mk(ALU_ADD, Z_ZERO, 1'b0, SIMD_ONE48);
        run(25'h2, 18'h3, 48'h0, c, 1, 0);
        run(25'h0, 18'h0, 48'h0, c, 2, 0);
        `CHK(result, 48'h0)
        run(25'h0, 18'h0, 48'h0, c, 1, 0);
        `CHK(result, 48'h6)
        $display("done pipeline");
        finish_test();
    end
endmodule
`default_nettype wire
